// ===== rtl/swk_consts.vh
// Summary of operation
// - flags1 holds eight peripheral pending flags
// - serial rx/tx read-only, all reset zero
// - flags2 bits 7,3,0; others read zero
// - events set flags regardless of enables
// - power-down only on sleep instruction
// - sleep entry always clears watchdog; it runs only if sleep-enabled
// - sleep entry clears power-down, sets time-out
// - cpu clock stopped, slow oscillator runs
// - timer1 keeps running on sleep-capable sources
// - converter runs on its dedicated oscillator
// - io pins hold pre-sleep drive state
// - non-watchdog resets act normally in sleep
// - reset sources reset, others continue execution
// - core prefetches next instruction during sleep
// - flag wake needs own enable, ext_irq_pend none; ignores global enable
// - global enable chooses inline or vector 0004h
// - watchdog cleared on every interrupt wake-up; reset wake gives no wdt_clear_ff pulse
// - pending enabled interrupt makes sleep a no-op
// - late interrupt: complete sleep, wake at once
// - crystal wake waits 1024 oscillator periods
// - regulator low-power in sleep when mode set
// - peripheral wake also needs peripheral enable
// - regulator mode bit 1, resets zero
`ifndef SWK_CONSTS_VH
`define SWK_CONSTS_VH
// ==========================================================
// register byte offsets
`define SWK_OFS_FLAGS1    12'h000
`define SWK_OFS_FLAGS2    12'h004
`define SWK_OFS_ENABLE1   12'h008
`define SWK_OFS_ENABLE2   12'h00C
`define SWK_OFS_CTRL      12'h010
`define SWK_OFS_REGCTL    12'h014
`define SWK_OFS_STATUS    12'h018
// ==========================================================
// field positions and masks
`define SWK_F1_RX         5
`define SWK_F1_TX         4
`define SWK_F1_WMASK      8'hCF
`define SWK_F2_MASK       8'h89
`define SWK_CTL_GIE       0
`define SWK_CTL_PERIPHERAL_IRQ_ENABLE      1
`define SWK_CTL_XTAL      2
`define SWK_CTL_TWOSPD    3
`define SWK_CTL_WDSLP     4
`define SWK_REG_PM        1
`define SWK_REG_RSVD      0
// ==========================================================
// reset values and timing
`define SWK_RST_FLAGS     8'h00
`define SWK_RST_REGCTL    8'h01
`define SWK_OST_PERIODS   1024
`define SWK_VECTOR        16'h0004
`endif

// ===== rtl/swk_sleep_ctrl.v
`timescale 1ns/10ps
`include "swk_consts.vh"
module swk_sleep_ctrl #(
  parameter OST_CYCLES = `SWK_OST_PERIODS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire [7:0]  evt1,
  input  wire [2:0]  evt2,
  input  wire        ext_irq_pend,
  input  wire        sleep_exec,
  input  wire        reset_wake_req,
  output reg         cpu_clk_en_ff,
  output reg         sleep_active_ff,
  output reg         wdt_clear_ff,
  output reg         wdt_run_ff,
  output reg         io_hold_ff,
  output reg         reg_lowpower_ff,
  output reg         prefetch_ff,
  output reg         vector_ff,
  output reg  [15:0] vector_addr_ff,
  output reg         device_reset_ff,
  output reg         power_down_status_ff,
  output reg         timeout_status_ff
);
  // ==========================================================
  // state encoding, one-hot
  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_SLP  = 4'b0010;
  localparam [3:0] ST_OST  = 4'b0100;
  localparam [3:0] ST_NEXT = 4'b1000;
  reg  [3:0]  state_ff;            // power state
  reg  [7:0]  flags1_ff;           // first request flags
  reg  [7:0]  flags2_ff;           // second request flags
  reg  [7:0]  en1_ff;              // first enables
  reg  [7:0]  en2_ff;              // second enables
  reg  [4:0]  ctl_ff;              // interrupt and clock control
  reg  [7:0]  regctl_ff;           // regulator control
  reg  [10:0] ost_ff;              // start-up wait counter
  reg         wake_gie_ff;         // global enable captured at wake
  wire        wr;                  // register write strobe
  wire [7:0]  wb;                  // written byte
  wire [7:0]  f1_set;              // event set terms
  wire [7:0]  f2_set;
  wire        wake_pend;           // an enabled interrupt is pending
  // ==========================================================
  // register write hit: strobe qualified by one register offset;
  // kept in one place so every register decodes the bus the same way
  function wr_hit;
    input        w;                // access-phase write strobe
    input [11:0] a;                // bus address
    input [11:0] ofs;              // register offset to match
    begin
      wr_hit = w & (a == ofs);
    end
  endfunction
  // ==========================================================
  // apb write strobe taken in the access phase
  assign wr = psel & penable & pwrite;
  assign wb = pwdata[7:0];
  // events always set flags, whatever the enables say
  assign f1_set = evt1;
  assign f2_set = {evt2[2], 3'b000, evt2[1], 2'b00, evt2[0]};
  // flag wake needs the own enable and peripheral enable, not global; ext_irq_pend wakes with no enable
  assign wake_pend = ext_irq_pend |
                     (ctl_ff[`SWK_CTL_PERIPHERAL_IRQ_ENABLE] &
                      (|(flags1_ff & en1_ff) | |(flags2_ff & en2_ff)));
  // ==========================================================
  // apb slave: single wait-free answer, unmapped reads as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `SWK_OFS_FLAGS1:  prdata_ff <= {24'h000000, flags1_ff};
          `SWK_OFS_FLAGS2:  prdata_ff <= {24'h000000, flags2_ff};
          `SWK_OFS_ENABLE1: prdata_ff <= {24'h000000, en1_ff};
          `SWK_OFS_ENABLE2: prdata_ff <= {24'h000000, en2_ff};
          `SWK_OFS_CTRL:    prdata_ff <= {27'h0000000, ctl_ff};
          `SWK_OFS_REGCTL:  prdata_ff <= {24'h000000, regctl_ff};
          `SWK_OFS_STATUS:  prdata_ff <= {28'h0000000, state_ff};
          default:          prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
  // ==========================================================
  // request flags: set wins over a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags1_ff    <= `SWK_RST_FLAGS;
      flags2_ff    <= `SWK_RST_FLAGS;
    end else begin
      // serial rx/tx mirror their source; software cannot write them
      flags1_ff[`SWK_F1_RX] <= evt1[`SWK_F1_RX];
      flags1_ff[`SWK_F1_TX] <= evt1[`SWK_F1_TX];
      // a write and an event in one cycle: the event wins, so no
      // condition is ever lost to a software clear
      if (wr_hit(wr, paddr, `SWK_OFS_FLAGS1))
        flags1_ff[7:6] <= wb[7:6] | f1_set[7:6];
      else
        flags1_ff[7:6] <= flags1_ff[7:6] | f1_set[7:6];
      if (wr_hit(wr, paddr, `SWK_OFS_FLAGS1))
        flags1_ff[3:0] <= wb[3:0] | f1_set[3:0];
      else
        flags1_ff[3:0] <= flags1_ff[3:0] | f1_set[3:0];
      // unimplemented bits of the second register are masked to zero
      if (wr_hit(wr, paddr, `SWK_OFS_FLAGS2))
        flags2_ff <= (wb | f2_set) & `SWK_F2_MASK;
      else
        flags2_ff <= (flags2_ff | f2_set) & `SWK_F2_MASK;
    end
  end
  // ==========================================================
  // enable, control and regulator registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en1_ff    <= 8'h00;
      en2_ff    <= 8'h00;
      ctl_ff    <= 5'h00;
      regctl_ff <= `SWK_RST_REGCTL;
    end else begin
      // first enables, one per pending flag
      if (wr_hit(wr, paddr, `SWK_OFS_ENABLE1))
        en1_ff <= wb;
      // second enables follow the implemented flag bits only
      if (wr_hit(wr, paddr, `SWK_OFS_ENABLE2))
        en2_ff <= wb & `SWK_F2_MASK;
      // global, peripheral, oscillator and watchdog-in-sleep control
      if (wr_hit(wr, paddr, `SWK_OFS_CTRL))
        ctl_ff <= wb[4:0];
      // reserved bit 0 stays set, upper bits read zero
      if (wr_hit(wr, paddr, `SWK_OFS_REGCTL))
        regctl_ff <= {6'h00, wb[`SWK_REG_PM], 1'b1};
    end
  end
  // ==========================================================
  // power state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff             <= ST_RUN;
      ost_ff               <= 11'h000;
      wake_gie_ff          <= 1'b0;
      cpu_clk_en_ff        <= 1'b1;
      sleep_active_ff      <= 1'b0;
      wdt_clear_ff         <= 1'b0;
      wdt_run_ff           <= 1'b1;
      io_hold_ff           <= 1'b0;
      reg_lowpower_ff      <= 1'b0;
      prefetch_ff          <= 1'b0;
      vector_ff            <= 1'b0;
      vector_addr_ff       <= 16'h0000;
      device_reset_ff      <= 1'b0;
      power_down_status_ff <= 1'b1;
      timeout_status_ff    <= 1'b1;
    end else begin
      wdt_clear_ff    <= 1'b0;
      prefetch_ff     <= 1'b0;
      vector_ff       <= 1'b0;
      // reset sources act the same asleep or awake
      device_reset_ff <= reset_wake_req;
      case (state_ff)
        ST_RUN: begin
          wdt_run_ff <= 1'b1;
          // only the sleep instruction powers down
          if (sleep_exec && !wake_pend) begin
            state_ff             <= ST_SLP;
            cpu_clk_en_ff        <= 1'b0;
            sleep_active_ff      <= 1'b1;
            io_hold_ff           <= 1'b1;
            wdt_clear_ff         <= 1'b1;
            wdt_run_ff           <= ctl_ff[`SWK_CTL_WDSLP];
            power_down_status_ff <= 1'b0;
            timeout_status_ff    <= 1'b1;
            prefetch_ff          <= 1'b1;
            reg_lowpower_ff      <= regctl_ff[`SWK_REG_PM];
          end
        end
        ST_SLP: begin
          // late interrupt still lets sleep complete, then wakes
          if (reset_wake_req) begin
            state_ff        <= ST_RUN;
            cpu_clk_en_ff   <= 1'b1;
            sleep_active_ff <= 1'b0;
            io_hold_ff      <= 1'b0;
            reg_lowpower_ff <= 1'b0;
          end else if (wake_pend) begin
            wdt_clear_ff    <= 1'b1;
            reg_lowpower_ff <= 1'b0;
            wake_gie_ff     <= ctl_ff[`SWK_CTL_GIE];
            ost_ff          <= OST_CYCLES[10:0] - 11'd1;
            if (ctl_ff[`SWK_CTL_XTAL] && !ctl_ff[`SWK_CTL_TWOSPD])
              state_ff <= ST_OST;
            else
              state_ff <= ST_NEXT;
          end
        end
        ST_OST: begin
          // crystal start-up wait
          if (ost_ff == 11'h000)
            state_ff <= ST_NEXT;
          else
            ost_ff <= ost_ff - 11'd1;
        end
        ST_NEXT: begin
          // resume; global enable decides inline or vector
          state_ff        <= ST_RUN;
          cpu_clk_en_ff   <= 1'b1;
          sleep_active_ff <= 1'b0;
          io_hold_ff      <= 1'b0;
          wdt_run_ff      <= 1'b1;
          vector_ff       <= wake_gie_ff;
          vector_addr_ff  <= wake_gie_ff ? `SWK_VECTOR : 16'h0000;
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end
endmodule

// ===== dv/swk_core_mdl.sv
`timescale 1ns/10ps
// ==========================================================
// core model: issues the sleep instruction
module swk_core_mdl (
  input  wire pclk,
  input  wire presetn,
  input  wire cpu_clk_en_ff,
  input  wire sleep_req,
  output reg  sleep_exec
);
  // a stopped core cannot execute, so no pulse while gated
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_exec <= 1'b0;
    end else begin
      sleep_exec <= sleep_req & cpu_clk_en_ff & ~sleep_exec;
    end
  end
endmodule

// ===== dv/swk_sleep_ctrl_sva.sv
`timescale 1ns/10ps
// ==========================================================
// port checker for the sleep controller
module swk_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        sleep_exec,
  input wire        reset_wake_req,
  input wire        cpu_clk_en_ff,
  input wire        sleep_active_ff,
  input wire        io_hold_ff,
  input wire        reg_lowpower_ff,
  input wire        prefetch_ff,
  input wire        vector_ff,
  input wire [15:0] vector_addr_ff,
  input wire        device_reset_ff,
  input wire        power_down_status_ff,
  input wire        timeout_status_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sleep_cause: assert property (
    $fell(cpu_clk_en_ff) |-> $past(sleep_exec)) else $error("gated without sleep");
  chk_entry_status: assert property (
    $fell(cpu_clk_en_ff) |-> !power_down_status_ff && timeout_status_ff)
    else $error("bad status on entry");
  chk_entry_fetch: assert property (
    $fell(cpu_clk_en_ff) |-> prefetch_ff) else $error("no prefetch");
  chk_clk_stop: assert property (
    sleep_active_ff |-> !cpu_clk_en_ff) else $error("clock runs in sleep");
  chk_io_hold: assert property (
    sleep_active_ff |-> io_hold_ff) else $error("pins not held");
  chk_vec_addr: assert property (
    vector_ff |-> vector_addr_ff == 16'h0004 && cpu_clk_en_ff) else $error("bad vector");
  chk_reset_wake: assert property (
    reset_wake_req |=> device_reset_ff) else $error("reset source ignored");
  chk_lp_sleep: assert property (
    reg_lowpower_ff |-> !cpu_clk_en_ff) else $error("low power while awake");
endmodule
bind swk_sleep_ctrl swk_chk u_chk (.pclk(pclk), .presetn(presetn), .sleep_exec(sleep_exec),
  .reset_wake_req(reset_wake_req), .cpu_clk_en_ff(cpu_clk_en_ff),
  .sleep_active_ff(sleep_active_ff), .io_hold_ff(io_hold_ff),
  .reg_lowpower_ff(reg_lowpower_ff), .prefetch_ff(prefetch_ff), .vector_ff(vector_ff),
  .vector_addr_ff(vector_addr_ff), .device_reset_ff(device_reset_ff),
  .power_down_status_ff(power_down_status_ff), .timeout_status_ff(timeout_status_ff));

// ===== dv/swk_sleep_ctrl_tb.sv
`timescale 1ns/10ps
`include "swk_consts.vh"
module swk_sleep_ctrl_tb;
  localparam OST = 8; // short start-up count keeps the run brief
  reg         pclk, presetn, psel, penable, pwrite, ext_irq_pend, reset_wake_req, sleep_req;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  evt1;
  reg  [2:0]  evt2;
  wire [31:0] prdata_ff;
  wire [15:0] vector_addr_ff;
  wire        pready_ff, pslverr_ff, cpu_clk_en_ff, sleep_active_ff, wdt_clear_ff, wdt_run_ff;
  wire        io_hold_ff, reg_lowpower_ff, prefetch_ff, vector_ff, device_reset_ff;
  wire        power_down_status_ff, timeout_status_ff, sleep_exec;
  integer     err_total, compares, n;
  reg         v, w;
  swk_sleep_ctrl #(.OST_CYCLES(OST)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .evt1(evt1), .evt2(evt2),
    .ext_irq_pend(ext_irq_pend), .sleep_exec(sleep_exec), .reset_wake_req(reset_wake_req),
    .cpu_clk_en_ff(cpu_clk_en_ff), .sleep_active_ff(sleep_active_ff),
    .wdt_clear_ff(wdt_clear_ff), .wdt_run_ff(wdt_run_ff), .io_hold_ff(io_hold_ff),
    .reg_lowpower_ff(reg_lowpower_ff), .prefetch_ff(prefetch_ff), .vector_ff(vector_ff),
    .vector_addr_ff(vector_addr_ff), .device_reset_ff(device_reset_ff),
    .power_down_status_ff(power_down_status_ff), .timeout_status_ff(timeout_status_ff));
  swk_core_mdl u_core (.pclk(pclk), .presetn(presetn), .cpu_clk_en_ff(cpu_clk_en_ff),
    .sleep_req(sleep_req), .sleep_exec(sleep_exec));
  // ==========================================================
  // shared helpers
  task stop_test;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer; read data is taken while pready stands high
  task apb(input wr, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) @(posedge pclk);
    rd = prdata_ff;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdchk(input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task slp;
    @(posedge pclk); sleep_req <= 1'b1;
    @(posedge pclk); sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task pulse1(input [7:0] e);
    @(posedge pclk); evt1 <= e;
    @(posedge pclk); evt1 <= 8'h00;
  endtask
  // ==========================================================
  // scenarios
  task t_flags;
    rdchk(`SWK_OFS_FLAGS1, 32'h0);
    rdchk(`SWK_OFS_FLAGS2, 32'h0);
    rdchk(`SWK_OFS_REGCTL, 32'h1);
    rdchk(12'h0FC, 32'h0);
    pulse1(8'hCF);
    @(posedge pclk); evt2 <= 3'h7;
    @(posedge pclk); evt2 <= 3'h0;
    rdchk(`SWK_OFS_FLAGS1, 32'hCF);
    rdchk(`SWK_OFS_FLAGS2, 32'h89);
    apb(1'b1, `SWK_OFS_FLAGS1, 32'hFF);
    rdchk(`SWK_OFS_FLAGS1, 32'hCF);
    apb(1'b1, `SWK_OFS_FLAGS1, 32'h0);
    apb(1'b1, `SWK_OFS_FLAGS2, 32'h0);
    rdchk(`SWK_OFS_FLAGS1, 32'h0);
  endtask
  // enabled flag already pending: sleep does nothing
  task t_noop;
    apb(1'b1, `SWK_OFS_ENABLE1, 32'h1);
    apb(1'b1, `SWK_OFS_CTRL, 32'h2);
    pulse1(8'h01);
    slp;
    chk(cpu_clk_en_ff, 1);
    chk(power_down_status_ff, 1);
    apb(1'b1, `SWK_OFS_FLAGS1, 32'h0);
  endtask
  task t_wake(input [7:0] ctl, input lng, input vec);
    apb(1'b1, `SWK_OFS_CTRL, {24'h0, ctl});
    slp;
    chk({cpu_clk_en_ff, power_down_status_ff, timeout_status_ff}, 3'b001);
    chk(wdt_run_ff, ctl[4]);
    pulse1(8'h01);
    n = 0; v = 0; w = 0;
    while (cpu_clk_en_ff !== 1'b1 && n < 200) begin
      @(posedge pclk); #1;
      n = n + 1; w = w | wdt_clear_ff; v = v | vector_ff;
    end
    repeat (3) begin
      @(posedge pclk); #1;
      v = v | vector_ff;
    end
    chk(cpu_clk_en_ff, 1);
    chk(n > OST, lng);
    chk(w, 1);
    chk(v, vec);
    apb(1'b1, `SWK_OFS_FLAGS1, 32'h0);
  endtask
  task t_reset_wake;
    apb(1'b1, `SWK_OFS_REGCTL, 32'h3);
    apb(1'b1, `SWK_OFS_CTRL, 32'h2);
    slp;
    chk(reg_lowpower_ff, 1);
    @(posedge pclk); reset_wake_req <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(device_reset_ff, 1);
    chk({cpu_clk_en_ff, sleep_active_ff, reg_lowpower_ff}, 3'b100);
    @(posedge pclk); reset_wake_req <= 1'b0;
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    err_total = 0; compares = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; evt1 = 8'h0; evt2 = 3'h0;
    ext_irq_pend = 1'b0; reset_wake_req = 1'b0; sleep_req = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_flags;
    t_noop;
    t_wake(8'h07, 1'b1, 1'b1);
    t_wake(8'h0E, 1'b0, 1'b0);
    t_reset_wake;
    stop_test;
  end
endmodule
